// file: design/gtidc_params.svh
// Purpose: Constants of the timer input and direction control block.
// Assumes: 16-bit registers on a plain word-addressed port.
// Notes: Included by the package and by every design module.
`ifndef GTIDC_PARAMS_SVH
`define GTIDC_PARAMS_SVH

`define GTIDC_ADDR_W 4
`define GTIDC_DATA_W 16
`define GTIDC_NTIM 3
`define GTIDC_NPINS 6
`define GTIDC_PS_W 12
`define GTIDC_IRQ_W 4

`define GTIDC_OFF_CORE_CTRL 4'h0
`define GTIDC_OFF_AUX_A_CTRL 4'h1
`define GTIDC_OFF_AUX_B_CTRL 4'h2
`define GTIDC_OFF_CORE_CNT 4'h3
`define GTIDC_OFF_AUX_A_CNT 4'h4
`define GTIDC_OFF_AUX_B_CNT 4'h5
`define GTIDC_OFF_IRQ_STAT 4'h6
`define GTIDC_OFF_IRQ_EN 4'h7
`define GTIDC_OFF_IRQ_CLR 4'h8

`define GTIDC_CTRL_RST 16'h0000
`define GTIDC_CNT_RST 16'h0000
`define GTIDC_CNT_MAX 16'hffff
`define GTIDC_CNT_MIN 16'h0000
`define GTIDC_IRQ_RST 4'h0
`define GTIDC_PS_RST 12'h000

`define GTIDC_INSEL_HI 2
`define GTIDC_INSEL_LO 0
`define GTIDC_MODE_HI 5
`define GTIDC_MODE_LO 3
`define GTIDC_RUN_BIT 6
`define GTIDC_SWDIR_BIT 7
`define GTIDC_EXTDIR_EN_BIT 8
`define GTIDC_REMOTE_BIT 9
`define GTIDC_CPS_HI 10
`define GTIDC_CPS_LO 9
`define GTIDC_CLR_AUX_A_BIT 10
`define GTIDC_CLR_CORE_BIT 11
`define GTIDC_IRQ_DIS_BIT 12
`define GTIDC_EDGE_FLAG_BIT 13
`define GTIDC_DIRCHG_FLAG_BIT 14
`define GTIDC_RDIR_BIT 15

`define GTIDC_CPS_DIV4 2'h1
`define GTIDC_CPS_DIV8 2'h0
`define GTIDC_CPS_DIV16 2'h3
`define GTIDC_CPS_DIV32 2'h2
`define GTIDC_EXP_DIV4 4'h2
`define GTIDC_EXP_DIV8 4'h3
`define GTIDC_EXP_DIV16 4'h4
`define GTIDC_EXP_DIV32 4'h5

`define GTIDC_EDGE_NONE 2'h0
`define GTIDC_EDGE_RISE 2'h1
`define GTIDC_EDGE_FALL 2'h2
`define GTIDC_EDGE_ANY 2'h3

`define GTIDC_IRQ_CORE_OVF 0
`define GTIDC_IRQ_AUX_A_OVF 1
`define GTIDC_IRQ_AUX_B_OVF 2
`define GTIDC_IRQ_AUX_B_INCR 3

`endif

// file: design/gtidc_pkg.sv
// Purpose: Types shared by the timer input and direction control modules.
// Assumes: Constants come from gtidc_params.svh.
// Notes: Each module keeps all its state in one packed struct.
`include "gtidc_params.svh"
`default_nettype none
package gtidc_pkg;
    typedef enum logic [2:0] {
        GTIDC_M_TIMER = 3'h0,
        GTIDC_M_COUNTER = 3'h1,
        GTIDC_M_GATED_LO = 3'h2,
        GTIDC_M_GATED_HI = 3'h3,
        GTIDC_M_RELOAD = 3'h4,
        GTIDC_M_CAPTURE = 3'h5,
        GTIDC_M_INCR_ROT = 3'h6,
        GTIDC_M_INCR_EDGE = 3'h7
    } gtidc_mode_t;

    typedef struct packed {
        logic [`GTIDC_NTIM-1:0][`GTIDC_DATA_W-1:0] ctrl;
        logic [`GTIDC_NTIM-1:0][`GTIDC_DATA_W-1:0] cnt;
        logic otl;
        logic otl_shadow;
        logic dir_b_prev;
        logic [`GTIDC_IRQ_W-1:0] irq_stat;
        logic [`GTIDC_IRQ_W-1:0] irq_en;
        logic [`GTIDC_DATA_W-1:0] rdata;
    } gtidc_state_t;

    typedef struct packed {
        logic [`GTIDC_NPINS-1:0] prev;
    } gtidc_edge_state_t;

    typedef struct packed {
        logic [`GTIDC_PS_W-1:0] cnt;
    } gtidc_ps_state_t;
endpackage : gtidc_pkg
`default_nettype wire

// file: design/gtidc_edge_det.sv
// Purpose: Rising and falling edge detection on the timer input pins.
// Assumes: Pins are already synchronous to core_clk.
// Notes: One register of previous samples; edges are one-cycle pulses.
`include "gtidc_params.svh"
`default_nettype none
module gtidc_edge_det (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Pins and edges
    input wire logic [`GTIDC_NPINS-1:0] pins,
    output logic [`GTIDC_NPINS-1:0] rise,
    output logic [`GTIDC_NPINS-1:0] fall
);
    gtidc_pkg::gtidc_edge_state_t st_r;
    gtidc_pkg::gtidc_edge_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pins;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar i = 0; i < `GTIDC_NPINS; i++) begin : g_pin
        assign rise[i] = pins[i] & ~st_r.prev[i];
        assign fall[i] = ~pins[i] & st_r.prev[i];
    end
endmodule : gtidc_edge_det
`default_nettype wire

// file: design/gtidc_prescaler.sv
// Purpose: Shared prescaler giving one count tick per timer.
// Assumes: Common select and per-timer input field as in the control registers.
// Notes: Divider is a power of two, so a tick is a run of ones in a free counter.
`include "gtidc_params.svh"
`default_nettype none
module gtidc_prescaler (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Divider selection
    input wire logic [1:0] common_prescale_sel,
    input wire logic [`GTIDC_NTIM-1:0][2:0] input_select_field,
    // Ticks
    output logic [`GTIDC_NTIM-1:0] tick
);
    gtidc_pkg::gtidc_ps_state_t st_r;
    gtidc_pkg::gtidc_ps_state_t st_nxt;
    logic [3:0] base_exp;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + `GTIDC_PS_W'(1);
        case (common_prescale_sel)
            `GTIDC_CPS_DIV4: base_exp = `GTIDC_EXP_DIV4;
            `GTIDC_CPS_DIV8: base_exp = `GTIDC_EXP_DIV8;
            `GTIDC_CPS_DIV16: base_exp = `GTIDC_EXP_DIV16;
            default: base_exp = `GTIDC_EXP_DIV32;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar k = 0; k < `GTIDC_NTIM; k++) begin : g_tick
        logic [3:0] expo;
        logic [`GTIDC_PS_W-1:0] mask;
        // Exponent tops out at 12, the counter width, so divide by 4096 fits
        assign expo = base_exp + {1'b0, input_select_field[k]};
        assign mask = ~({`GTIDC_PS_W{1'b1}} << expo);
        assign tick[k] = (st_r.cnt & mask) == mask;
    end
endmodule : gtidc_prescaler
`default_nettype wire

// file: design/gtidc_top.sv
// Purpose: Core and two auxiliary 16-bit timers with input edge, direction and link logic.
// Assumes: Pins synchronous to core_clk; registers word-addressed on a plain port.
// Notes: Capture/reload storage lives outside; aux_a_trig/aux_b_trig announce its events.
//
// Local design decisions: the register addresses and the plain strobed port.
`include "gtidc_params.svh"
`default_nettype none
module gtidc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [`GTIDC_ADDR_W-1:0] reg_addr,
    input wire logic [`GTIDC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`GTIDC_DATA_W-1:0] reg_rdata,
    // Timer pins
    input wire logic core_count_pin,
    input wire logic core_direction_pin,
    input wire logic aux_a_count_pin,
    input wire logic aux_a_direction_pin,
    input wire logic aux_b_count_pin,
    input wire logic aux_b_direction_pin,
    // Events out
    output logic core_toggle_latch,
    output logic aux_a_trig,
    output logic aux_b_trig,
    output logic irq
);
    gtidc_pkg::gtidc_state_t st_r;
    gtidc_pkg::gtidc_state_t st_nxt;

    logic [`GTIDC_NPINS-1:0] pins;
    logic [`GTIDC_NPINS-1:0] rise;
    logic [`GTIDC_NPINS-1:0] fall;
    logic [`GTIDC_NTIM-1:0] tick;
    logic [`GTIDC_NTIM-1:0][2:0] insel;
    logic [`GTIDC_NTIM-1:0] dir;
    logic [`GTIDC_NTIM-1:0] cnt_evt;
    logic [`GTIDC_NTIM-1:0] trig;
    logic [`GTIDC_NTIM-1:0] ovf;
    logic [`GTIDC_NTIM-1:0] clr;
    logic [`GTIDC_NTIM-1:0] wr_cnt;
    logic otl_rise;
    logic otl_fall;
    logic edge_hit_b;
    logic dirchg_b;
    logic incr_req;
    logic wr_ctrl_b;

    assign pins = {aux_b_direction_pin, aux_b_count_pin, aux_a_direction_pin,
                   aux_a_count_pin, core_direction_pin, core_count_pin};

    gtidc_edge_det u_edge (
        .core_clk(core_clk),
        .resetn(resetn),
        .pins(pins),
        .rise(rise),
        .fall(fall)
    );

    gtidc_prescaler u_ps (
        .core_clk(core_clk),
        .resetn(resetn),
        .common_prescale_sel(st_r.ctrl[0][`GTIDC_CPS_HI:`GTIDC_CPS_LO]),
        .input_select_field(insel),
        .tick(tick)
    );

    function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            `GTIDC_EDGE_RISE: edge_pick = r;
            `GTIDC_EDGE_FALL: edge_pick = f;
            `GTIDC_EDGE_ANY: edge_pick = r | f;
            default: edge_pick = 1'b0;
        endcase
    endfunction : edge_pick

    // Shadow trails the toggle latch by one cycle; a difference is a latch edge
    assign otl_rise = st_r.otl & ~st_r.otl_shadow;
    assign otl_fall = ~st_r.otl & st_r.otl_shadow;

    for (genvar k = 0; k < `GTIDC_NTIM; k++) begin : g_tim
        gtidc_pkg::gtidc_mode_t mode;
        logic [`GTIDC_DATA_W-1:0] c;
        logic run;
        logic own_edge;
        logic link_edge;
        logic incr_edge;
        logic gate;
        logic evt;
        assign c = st_r.ctrl[k];
        assign mode = gtidc_pkg::gtidc_mode_t'(c[`GTIDC_MODE_HI:`GTIDC_MODE_LO]);
        assign insel[k] = c[`GTIDC_INSEL_HI:`GTIDC_INSEL_LO];
        if (k == 0) begin : g_core_run
            assign run = c[`GTIDC_RUN_BIT];
        end else begin : g_aux_run
            assign run = c[`GTIDC_REMOTE_BIT] ? st_r.ctrl[0][`GTIDC_RUN_BIT] : c[`GTIDC_RUN_BIT];
        end
        // Pin is ignored unless external direction is enabled
        assign dir[k] = c[`GTIDC_EXTDIR_EN_BIT] ? (pins[2*k+1] ^ c[`GTIDC_SWDIR_BIT])
                                                 : c[`GTIDC_SWDIR_BIT];
        assign own_edge = ~insel[k][2] & edge_pick(insel[k][1:0], rise[2*k], fall[2*k]);
        assign link_edge = insel[k][2] & edge_pick(insel[k][1:0], otl_rise, otl_fall);
        assign incr_edge = ~insel[k][2] &
                           ((insel[k][0] & (rise[2*k] | fall[2*k])) |
                            (insel[k][1] & (rise[2*k+1] | fall[2*k+1])));
        assign gate = (mode == gtidc_pkg::GTIDC_M_GATED_LO) ? ~pins[2*k] : pins[2*k];
        always_comb begin
            evt = 1'b0;
            trig[k] = 1'b0;
            case (mode)
                gtidc_pkg::GTIDC_M_TIMER: evt = tick[k];
                gtidc_pkg::GTIDC_M_GATED_LO,
                gtidc_pkg::GTIDC_M_GATED_HI: evt = tick[k] & gate;
                gtidc_pkg::GTIDC_M_COUNTER: evt = (k == 0) ? own_edge : (own_edge | link_edge);
                gtidc_pkg::GTIDC_M_RELOAD: trig[k] = (k != 0) & (own_edge | link_edge);
                gtidc_pkg::GTIDC_M_CAPTURE: trig[k] = (k != 0) & own_edge;
                gtidc_pkg::GTIDC_M_INCR_ROT,
                gtidc_pkg::GTIDC_M_INCR_EDGE: evt = incr_edge;
                default: evt = 1'b0;
            endcase
        end
        assign cnt_evt[k] = run & evt;
        assign ovf[k] = cnt_evt[k] & (dir[k] ? (st_r.cnt[k] == `GTIDC_CNT_MIN)
                                             : (st_r.cnt[k] == `GTIDC_CNT_MAX));
        assign wr_cnt[k] = reg_wr & (reg_addr == (`GTIDC_OFF_CORE_CNT + `GTIDC_ADDR_W'(k)));
    end

    assign clr[0] = st_r.ctrl[2][`GTIDC_CLR_CORE_BIT] & fall[4];
    assign clr[1] = st_r.ctrl[2][`GTIDC_CLR_AUX_A_BIT] & fall[5];
    assign clr[2] = 1'b0;

    assign wr_ctrl_b = reg_wr & (reg_addr == `GTIDC_OFF_AUX_B_CTRL);
    // Counted pin edges and toggle latch edges count as seen edges; prescaler ticks do not
    assign edge_hit_b = cnt_evt[2] & (insel[2] != 3'h0) &
                        (st_r.ctrl[2][`GTIDC_MODE_HI:`GTIDC_MODE_LO] != gtidc_pkg::GTIDC_M_TIMER) &
                        (st_r.ctrl[2][`GTIDC_MODE_HI:`GTIDC_MODE_LO] != gtidc_pkg::GTIDC_M_GATED_LO) &
                        (st_r.ctrl[2][`GTIDC_MODE_HI:`GTIDC_MODE_LO] != gtidc_pkg::GTIDC_M_GATED_HI);
    assign dirchg_b = dir[2] != st_r.dir_b_prev;
    assign incr_req = st_r.ctrl[2][`GTIDC_MODE_HI] & st_r.ctrl[2][`GTIDC_MODE_HI-1] &
                      ~st_r.ctrl[2][`GTIDC_IRQ_DIS_BIT] & (edge_hit_b | dirchg_b);

    always_comb begin
        logic [`GTIDC_IRQ_W-1:0] set;
        set = '0;
        st_nxt = st_r;
        for (int k = 0; k < `GTIDC_NTIM; k++) begin
            // Software write beats a link clear, which beats a count step
            if (wr_cnt[k]) begin
                st_nxt.cnt[k] = reg_wdata;
            end else if (clr[k]) begin
                st_nxt.cnt[k] = `GTIDC_CNT_RST;
            end else if (cnt_evt[k]) begin
                st_nxt.cnt[k] = dir[k] ? st_r.cnt[k] - `GTIDC_DATA_W'(1) : st_r.cnt[k] + `GTIDC_DATA_W'(1);
            end
        end
        st_nxt.otl = st_r.otl ^ ovf[0];
        st_nxt.otl_shadow = st_r.otl;
        st_nxt.dir_b_prev = dir[2];
        if (edge_hit_b) begin
            st_nxt.ctrl[2][`GTIDC_EDGE_FLAG_BIT] = 1'b1;
        end
        if (dirchg_b) begin
            st_nxt.ctrl[2][`GTIDC_DIRCHG_FLAG_BIT] = 1'b1;
        end
        if (reg_wr) begin
            case (reg_addr)
                `GTIDC_OFF_CORE_CTRL: st_nxt.ctrl[0] = reg_wdata;
                `GTIDC_OFF_AUX_A_CTRL: st_nxt.ctrl[1] = reg_wdata;
                // Write lands after the hardware set, so it wins; rotation bit stays read-only
                `GTIDC_OFF_AUX_B_CTRL: st_nxt.ctrl[2] = {1'b0, reg_wdata[`GTIDC_RDIR_BIT-1:0]};
                `GTIDC_OFF_IRQ_EN: st_nxt.irq_en = reg_wdata[`GTIDC_IRQ_W-1:0];
                `GTIDC_OFF_IRQ_CLR: st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[`GTIDC_IRQ_W-1:0];
                default: ;
            endcase
        end
        set[`GTIDC_IRQ_CORE_OVF] = ovf[0];
        set[`GTIDC_IRQ_AUX_A_OVF] = ovf[1];
        set[`GTIDC_IRQ_AUX_B_OVF] = ovf[2];
        set[`GTIDC_IRQ_AUX_B_INCR] = incr_req;
        // Status set is applied last so a same-cycle clear never loses an event
        st_nxt.irq_stat = st_nxt.irq_stat | set;
        st_nxt.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `GTIDC_OFF_CORE_CTRL: st_nxt.rdata = st_r.ctrl[0];
                `GTIDC_OFF_AUX_A_CTRL: st_nxt.rdata = st_r.ctrl[1];
                `GTIDC_OFF_AUX_B_CTRL: st_nxt.rdata = {dir[2], st_r.ctrl[2][`GTIDC_RDIR_BIT-1:0]};
                `GTIDC_OFF_CORE_CNT: st_nxt.rdata = st_r.cnt[0];
                `GTIDC_OFF_AUX_A_CNT: st_nxt.rdata = st_r.cnt[1];
                `GTIDC_OFF_AUX_B_CNT: st_nxt.rdata = st_r.cnt[2];
                `GTIDC_OFF_IRQ_STAT: st_nxt.rdata = {{(`GTIDC_DATA_W-`GTIDC_IRQ_W){1'b0}}, st_r.irq_stat};
                `GTIDC_OFF_IRQ_EN: st_nxt.rdata = {{(`GTIDC_DATA_W-`GTIDC_IRQ_W){1'b0}}, st_r.irq_en};
                default: st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign core_toggle_latch = st_r.otl;
    assign aux_a_trig = trig[1];
    assign aux_b_trig = trig[2];
    assign irq = |(st_r.irq_stat & st_r.irq_en);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    aux_a_clear_a: assert property (
        (st_r.ctrl[2][`GTIDC_CLR_AUX_A_BIT] && $fell(aux_b_direction_pin) && !wr_cnt[1])
        |=> st_r.cnt[1] == `GTIDC_CNT_MIN) else $error("aux A not cleared by direction pin fall");
    core_clear_a: assert property (
        (st_r.ctrl[2][`GTIDC_CLR_CORE_BIT] && $fell(aux_b_count_pin) && !wr_cnt[0])
        |=> st_r.cnt[0] == `GTIDC_CNT_MIN) else $error("core not cleared by count pin fall");
    incr_gate_a: assert property (
        incr_req |-> !st_r.ctrl[2][`GTIDC_IRQ_DIS_BIT] ##1 st_r.irq_stat[`GTIDC_IRQ_AUX_B_INCR])
        else $error("incremental request while disabled or not recorded");
    edge_flag_a: assert property (
        (edge_hit_b && !wr_ctrl_b) |=> st_r.ctrl[2][`GTIDC_EDGE_FLAG_BIT]) else $error("edge flag missed");
    dirchg_flag_a: assert property (
        ($changed(dir[2]) && !wr_ctrl_b) |-> ##1 st_r.ctrl[2][`GTIDC_DIRCHG_FLAG_BIT])
        else $error("direction change flag missed");
    rdir_read_a: assert property (
        (reg_rd && reg_addr == `GTIDC_OFF_AUX_B_CTRL) |=> reg_rdata[`GTIDC_RDIR_BIT] == $past(dir[2]))
        else $error("rotation bit does not show direction");
    sw_dir_a: assert property (
        !st_r.ctrl[2][`GTIDC_EXTDIR_EN_BIT] |-> dir[2] == st_r.ctrl[2][`GTIDC_SWDIR_BIT])
        else $error("software direction not followed");
    ext_dir_a: assert property (
        st_r.ctrl[2][`GTIDC_EXTDIR_EN_BIT] |-> dir[2] == (aux_b_direction_pin ^ st_r.ctrl[2][`GTIDC_SWDIR_BIT]))
        else $error("external direction not followed");
    timer_tick_a: assert property (
        (st_r.ctrl[0][`GTIDC_MODE_HI:`GTIDC_MODE_LO] == gtidc_pkg::GTIDC_M_TIMER && !tick[0]
         && !wr_cnt[0] && !clr[0]) |=> $stable(st_r.cnt[0])) else $error("core counted without tick");
    core_rise_a: assert property (
        (st_r.ctrl[0][`GTIDC_MODE_HI:`GTIDC_MODE_LO] == gtidc_pkg::GTIDC_M_COUNTER && insel[0] == 3'h1
         && st_r.ctrl[0][`GTIDC_RUN_BIT] && !dir[0] && $rose(core_count_pin) && !wr_cnt[0] && !clr[0])
        |=> st_r.cnt[0] == $past(st_r.cnt[0]) + `GTIDC_DATA_W'(1)) else $error("core missed rising edge");
endmodule : gtidc_top
`default_nettype wire

// file: bench/gtidc_pins_model.sv
// Purpose: Outside source for the six timer input pins (encoder, gate and count lines).
// Assumes: Pins are plain levels, changed just after a rising core_clk edge.
// Notes: No pull-ups on these lines; a level holds until the bench changes it.
`default_nettype none
module gtidc_pins_model (
    // Clock
    input wire logic core_clk,
    // Pins
    output logic core_count_pin,
    output logic core_direction_pin,
    output logic aux_a_count_pin,
    output logic aux_a_direction_pin,
    output logic aux_b_count_pin,
    output logic aux_b_direction_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] pins_r = 6'h00;
    assign core_count_pin = pins_r[0];
    assign core_direction_pin = pins_r[1];
    assign aux_a_count_pin = pins_r[2];
    assign aux_a_direction_pin = pins_r[3];
    assign aux_b_count_pin = pins_r[4];
    assign aux_b_direction_pin = pins_r[5];
    // Levels held three edges so the block sees each edge as one sample change
    task automatic drive(input logic [5:0] m, input logic v);
        @(posedge core_clk);
        pins_r <= v ? (pins_r | m) : (pins_r & ~m);
        repeat (3) @(posedge core_clk);
    endtask : drive
    task automatic pulse(input logic [5:0] m);
        drive(m, 1'b1);
        drive(m, 1'b0);
    endtask : pulse
endmodule : gtidc_pins_model
`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for timer input, direction and link control.
// Assumes: Register reads answer in the cycle after the strobe.
// Notes: Timer-mode counts get one step of slack, as the divider phase is free.
`include "gtidc_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic p0, p1, p2, p3, p4, p5;
    logic core_toggle_latch, aux_a_trig, aux_b_trig, irq;
    int n_fail = 0;
    int n_compared = 0;
    int n_trig_a = 0;
    int n_trig_b = 0;
    logic [15:0] d;
    logic x;
    logic [15:0] edge_cnt [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0002};
    logic [15:0] ps_ctrl [5] = '{16'h0240, 16'h0040, 16'h0640, 16'h0440, 16'h0441};
    int ps_div [5] = '{4, 8, 16, 32, 64};
    logic [15:0] incr_cnt [4] = '{16'h0000, 16'h0002, 16'h0002, 16'h0004};

    gtidc_top u_gtidc_top (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_count_pin(p0), .core_direction_pin(p1),
        .aux_a_count_pin(p2), .aux_a_direction_pin(p3), .aux_b_count_pin(p4), .aux_b_direction_pin(p5),
        .core_toggle_latch(core_toggle_latch), .aux_a_trig(aux_a_trig), .aux_b_trig(aux_b_trig), .irq(irq));
    gtidc_pins_model u_gtidc_pins_model (.core_clk(core_clk), .core_count_pin(p0), .core_direction_pin(p1),
        .aux_a_count_pin(p2), .aux_a_direction_pin(p3), .aux_b_count_pin(p4), .aux_b_direction_pin(p5));

    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (aux_a_trig === 1'b1) n_trig_a++;
        if (aux_b_trig === 1'b1) n_trig_b++;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        // Tests take under 8000 cycles; this allows about 20000
        #400000;
        n_fail++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        // Everything reads zero after reset, the unmapped index too
        for (int a = 0; a < 10; a++) begin
            if (a != 8) begin
                rd(4'(a), d);
                chk(d, 16'h0000);
            end
        end
        chk({15'h0000, irq}, 16'h0000);
        // Direction table; bit 15 is written opposite to prove it read-only
        for (int i = 0; i < 8; i++) begin
            x = i[1] ? (i[2] ^ i[0]) : i[0];
            u_gtidc_pins_model.drive(6'h20, i[2]);
            wr(`GTIDC_OFF_AUX_B_CTRL, {~x, 6'h00, i[1], i[0], 7'h00});
            rd(`GTIDC_OFF_AUX_B_CTRL, d);
            chk({15'h0000, d[15]}, {15'h0000, x});
        end
        u_gtidc_pins_model.drive(6'h20, 1'b0);
        // Incremental mode: direction reversal sets the sticky flag and the request
        wr(`GTIDC_OFF_IRQ_EN, 16'h0000);
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h0030);
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h0030);
        wr(`GTIDC_OFF_IRQ_CLR, 16'h000f);
        rd(`GTIDC_OFF_AUX_B_CTRL, d);
        chk(d, 16'h0030);
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h00b0);
        rd(`GTIDC_OFF_AUX_B_CTRL, d);
        chk(d, 16'hc0b0);
        rd(`GTIDC_OFF_IRQ_STAT, d);
        chk(d, 16'h0008);
        chk({15'h0000, irq}, 16'h0000);
        wr(`GTIDC_OFF_IRQ_EN, 16'h0008);
        // Let the enable write settle before looking at the level
        #1;
        chk({15'h0000, irq}, 16'h0001);
        wr(`GTIDC_OFF_IRQ_CLR, 16'h0008);
        rd(`GTIDC_OFF_IRQ_STAT, d);
        chk(d, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // With the disable bit set the flag still sets but no request follows
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h10b0);
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h1030);
        rd(`GTIDC_OFF_AUX_B_CTRL, d);
        chk(d, 16'h5030);
        rd(`GTIDC_OFF_IRQ_STAT, d);
        chk(d, 16'h0000);
        // Counter mode rising edge: one count, edge flag sticky until written 0
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h0049);
        wr(`GTIDC_OFF_AUX_B_CNT, 16'h0000);
        u_gtidc_pins_model.pulse(6'h10);
        rd(`GTIDC_OFF_AUX_B_CTRL, d);
        chk(d, 16'h2049);
        rd(`GTIDC_OFF_AUX_B_CNT, d);
        chk(d, 16'h0001);
        wr(`GTIDC_OFF_AUX_B_CTRL, 16'h0049);
        rd(`GTIDC_OFF_AUX_B_CTRL, d);
        chk(d, 16'h0049);
        // Falling edges of aux B pins clear the linked timers only when enabled
        wr(`GTIDC_OFF_CORE_CTRL, 16'h0000);
        wr(`GTIDC_OFF_AUX_A_CTRL, 16'h0000);
        for (int e = 0; e < 2; e++) begin
            wr(`GTIDC_OFF_CORE_CNT, 16'h1234);
            wr(`GTIDC_OFF_AUX_A_CNT, 16'h5678);
            wr(`GTIDC_OFF_AUX_B_CTRL, e ? 16'h0c00 : 16'h0000);
            u_gtidc_pins_model.pulse(6'h30);
            rd(`GTIDC_OFF_CORE_CNT, d);
            chk(d, e ? 16'h0000 : 16'h1234);
            rd(`GTIDC_OFF_AUX_A_CNT, d);
            chk(d, e ? 16'h0000 : 16'h5678);
        end
        // Edge codes stay within 000-011; 1XX selects toggle latch edges, but only in aux counter and reload modes
        for (int s = 0; s < 4; s++) begin
            wr(`GTIDC_OFF_CORE_CTRL, 16'h0048 | 16'(s));
            wr(`GTIDC_OFF_AUX_A_CTRL, 16'h0068 | 16'(s));
            wr(`GTIDC_OFF_CORE_CNT, 16'h0000);
            n_trig_a = 0;
            u_gtidc_pins_model.pulse(6'h05);
            rd(`GTIDC_OFF_CORE_CNT, d);
            chk(d, edge_cnt[s]);
            chk(16'(n_trig_a), edge_cnt[s]);
        end
        // Incremental mode: count pin, direction pin or both, each edge one step
        for (int s = 0; s < 4; s++) begin
            wr(`GTIDC_OFF_CORE_CTRL, 16'h0070 | 16'(s));
            wr(`GTIDC_OFF_CORE_CNT, 16'h0000);
            u_gtidc_pins_model.pulse(6'h01);
            u_gtidc_pins_model.pulse(6'h02);
            rd(`GTIDC_OFF_CORE_CNT, d);
            chk(d, incr_cnt[s]);
        end
        // Reload mode on toggle latch edges; two overflows give one rise and one fall
        wr(`GTIDC_OFF_CORE_CTRL, 16'h0049);
        for (int s = 5; s < 8; s++) begin
            wr(`GTIDC_OFF_AUX_B_CTRL, 16'h0060 | 16'(s));
            n_trig_b = 0;
            for (int r = 0; r < 2; r++) begin
                wr(`GTIDC_OFF_CORE_CNT, 16'hffff);
                u_gtidc_pins_model.pulse(6'h01);
                chk({15'h0000, core_toggle_latch}, r ? 16'h0000 : 16'h0001);
            end
            chk(16'(n_trig_b), (s == 7) ? 16'h0002 : 16'h0001);
        end
        // Gated modes with the gate pin low: active-low runs, active-high stops
        for (int g = 0; g < 2; g++) begin
            wr(`GTIDC_OFF_CORE_CTRL, g ? 16'h0258 : 16'h0250);
            wr(`GTIDC_OFF_CORE_CNT, 16'h0000);
            repeat (40) @(posedge core_clk);
            rd(`GTIDC_OFF_CORE_CNT, d);
            chk({15'h0000, g ? (d == 16'h0000) : (d >= 16'h000a && d <= 16'h000b)}, 16'h0001);
        end
        // Timer mode divider: fifty periods should give fifty counts
        for (int k = 0; k < 5; k++) begin
            wr(`GTIDC_OFF_CORE_CTRL, ps_ctrl[k]);
            wr(`GTIDC_OFF_CORE_CNT, 16'h0000);
            repeat (ps_div[k] * 50) @(posedge core_clk);
            rd(`GTIDC_OFF_CORE_CNT, d);
            chk({15'h0000, (d >= 16'h0031 && d <= 16'h0033)}, 16'h0001);
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
